/* File: hw/plc_event_counter_bank.sv */
// Bank of 16-bit up counters and 32-bit up/down counters with published contacts.
// Assumes scan_end is a one-cycle pulse from core_clk logic; count and power pins are async.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module plc_event_counter_bank #(
  parameter int NUM_NARROW = 2048,
  parameter int NUM_WIDE = 64,
  parameter int NUM_AXIS = 8,
  parameter int NUM_DATA = 256
) (
  // Clock and reset
  input logic core_clk,
  input logic rst_b,
  // Counter inputs and program scan
  input logic [NUM_NARROW-1:0] narrow_count_in,
  input logic [NUM_WIDE+NUM_AXIS-1:0] wide_count_in,
  input logic power_loss,
  input logic scan_end,
  // Published contacts and interrupt
  output logic [NUM_NARROW-1:0] narrow_contact,
  output logic [NUM_WIDE+NUM_AXIS-1:0] wide_contact,
  output logic irq,
  // AXI4-Lite write channels
  input logic [plc_tally_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [plc_tally_pkg::DATA_W-1:0] s_axi_wdata,
  input logic [plc_tally_pkg::STRB_W-1:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read channels
  input logic [plc_tally_pkg::ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [plc_tally_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready
);
  import plc_tally_pkg::*;

  localparam int NN = NUM_NARROW;
  localparam int NW = NUM_WIDE + NUM_AXIS;
  localparam int ND = NUM_DATA;

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the bank
  typedef struct packed {
    logic [NN-1:0] n_s1;
    logic [NN-1:0] n_s2;
    logic [NN-1:0] n_s3;
    logic [NW-1:0] w_s1;
    logic [NW-1:0] w_s2;
    logic [NW-1:0] w_s3;
    logic pl_s1;
    logic pl_s2;
    logic pl_s3;
    logic [NN-1:0][15:0] n_cur;
    logic [NN-1:0][31:0] n_cfg;
    logic [NN-1:0] n_int;
    logic [NN-1:0] n_pub;
    logic [NW-1:0][31:0] w_cur;
    logic [NW-1:0][31:0] w_set;
    logic [NW-1:0][WCFG_W-1:0] w_cfg;
    logic [NW-1:0] w_dir;
    logic [NW-1:0] w_int;
    logic [NW-1:0] w_pub;
    logic [ND-1:0][15:0] dreg;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Effective narrow setting: constant or data register, limited, zero taken as one
  function automatic logic [15:0] narrow_eff(input logic [31:0] cfg,
                                             input logic [ND-1:0][15:0] dr);
    logic [15:0] raw;
    raw = cfg[NCFG_USE_DATA] ? dr[cfg[NCFG_IDX_LSB +: IDX_W]] : cfg[15:0];
    raw = raw & NARROW_SET_MASK;
    return (raw == '0) ? NARROW_ONE : raw;
  endfunction

  // Wide setting: signed constant or low/high pair of data registers
  function automatic logic [31:0] wide_eff(input logic [WCFG_W-1:0] cfg,
                                           input logic [31:0] cst,
                                           input logic [ND-1:0][15:0] dr);
    logic [IDX_W-1:0] lo;
    logic [IDX_W-1:0] hi;
    lo = cfg[WCFG_IDX_LSB +: IDX_W];
    hi = IDX_W'(lo + 1'b1);
    return cfg[WCFG_USE_DATA] ? {dr[hi], dr[lo]} : cst;
  endfunction

  // Address falls inside a window of the given word count
  function automatic logic in_win(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                  input int words);
    return (a >= base) && ({16'h0000, a} < ({16'h0000, base} + 32'(words * 4)));
  endfunction

  // Word index within a window
  function automatic int win_idx(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    return int'(ADDR_W'(a - base) >> 2);
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [STRB_W-1:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register read: hit flag above the data word
  function automatic logic [32:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    int k;
    r = '0;
    k = 0;
    if (a == IRQ_STATUS_OFS) begin
      r = {1'b1, 30'h0, s.irq_st};
    end else if (a == IRQ_MASK_OFS) begin
      r = {1'b1, 30'h0, s.irq_mask};
    end else if (a == CLEAR_OFS) begin
      r = {1'b1, 32'h0};
    end else if (in_win(a, NARROW_CUR_BASE, NN)) begin
      r = {1'b1, 16'h0, s.n_cur[win_idx(a, NARROW_CUR_BASE)]};
    end else if (in_win(a, NARROW_CFG_BASE, NN)) begin
      r = {1'b1, s.n_cfg[win_idx(a, NARROW_CFG_BASE)]};
    end else if (in_win(a, WIDE_CUR_BASE, NW)) begin
      r = {1'b1, s.w_cur[win_idx(a, WIDE_CUR_BASE)]};
    end else if (in_win(a, WIDE_SET_BASE, NW)) begin
      r = {1'b1, s.w_set[win_idx(a, WIDE_SET_BASE)]};
    end else if (in_win(a, WIDE_CFG_BASE, NW)) begin
      r = {1'b1, 16'h0, s.w_cfg[win_idx(a, WIDE_CFG_BASE)]};
    end else if (in_win(a, DATA_BASE, ND)) begin
      r = {1'b1, 16'h0, s.dreg[win_idx(a, DATA_BASE)]};
    end else if (in_win(a, WIDE_DIR_BASE, (NW + 31) / 32)) begin
      k = win_idx(a, WIDE_DIR_BASE) * 32;
      r[32] = 1'b1;
      for (int b = 0; b < 32; b++) begin
        if (k + b < NW) r[b] = s.w_dir[k + b];
      end
    end else if (in_win(a, NARROW_PUB_BASE, (NN + 31) / 32)) begin
      k = win_idx(a, NARROW_PUB_BASE) * 32;
      r[32] = 1'b1;
      for (int b = 0; b < 32; b++) begin
        if (k + b < NN) r[b] = s.n_pub[k + b];
      end
    end else if (in_win(a, WIDE_PUB_BASE, (NW + 31) / 32)) begin
      k = win_idx(a, WIDE_PUB_BASE) * 32;
      r[32] = 1'b1;
      for (int b = 0; b < 32; b++) begin
        if (k + b < NW) r[b] = s.w_pub[k + b];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decoded events of the current cycle
  logic do_write;
  logic pl_evt;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;

  // Write fires once address and data are both held
  assign do_write = q.aw_full && q.w_full;
  assign pl_evt = q.pl_s2 && !q.pl_s3;
  assign wa = q.aw_addr & WORD_MASK;
  assign ra = s_axi_araddr & WORD_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [15:0] ne;
    logic [15:0] nn;
    logic [31:0] we;
    logic [31:0] wn;
    logic [32:0] rw;
    logic [31:0] mg;
    logic clr_n;
    logic clr_w;
    logic [CLR_IDX_W-1:0] clr_i;
    logic rd_clr;
    logic [IRQ_W-1:0] ev;
    int k;
    ne = '0;
    nn = '0;
    we = '0;
    wn = '0;
    rw = '0;
    mg = '0;
    k = 0;
    rd_clr = 1'b0;
    ev = '0;
    d = q;
    // Input synchronisers and edge history
    d.n_s1 = narrow_count_in;
    d.n_s2 = q.n_s1;
    d.n_s3 = q.n_s2;
    d.w_s1 = wide_count_in;
    d.w_s2 = q.w_s1;
    d.w_s3 = q.w_s2;
    d.pl_s1 = power_loss;
    d.pl_s2 = q.pl_s1;
    d.pl_s3 = q.pl_s2;
    // Clear instruction decode
    clr_n = do_write && (wa == CLEAR_OFS) && !q.w_data[CLR_WIDE_BIT];
    clr_w = do_write && (wa == CLEAR_OFS) && q.w_data[CLR_WIDE_BIT];
    clr_i = q.w_data[CLR_IDX_W-1:0];
    // Narrow counters
    for (int i = 0; i < NN; i++) begin
      ne = narrow_eff(q.n_cfg[i], q.dreg);
      nn = 16'(q.n_cur[i] + NARROW_ONE);
      if (clr_n && (clr_i == CLR_IDX_W'(i))) begin
        d.n_cur[i] = '0;
        d.n_int[i] = 1'b0;
      end else if (pl_evt && !q.n_cfg[i][NCFG_LATCH]) begin
        d.n_cur[i] = '0;
        d.n_int[i] = 1'b0;
        d.n_pub[i] = 1'b0;
      end else if (q.n_s2[i] && !q.n_s3[i]) begin
        if ($signed(q.n_cur[i]) > $signed(ne)) begin
          d.n_cur[i] = ne;
          d.n_int[i] = 1'b1;
          ev[IRQ_NARROW_BIT] = 1'b1;
        end else if (q.n_cur[i] != ne) begin
          d.n_cur[i] = nn;
          if (nn == ne) begin
            d.n_int[i] = 1'b1;
            ev[IRQ_NARROW_BIT] = 1'b1;
          end
        end
      end
    end
    // Wide counters; axis slots sit above the general ones with the same logic
    for (int i = 0; i < NW; i++) begin
      we = wide_eff(q.w_cfg[i], q.w_set[i], q.dreg);
      wn = q.w_dir[i] ? 32'(q.w_cur[i] - WIDE_ONE) : 32'(q.w_cur[i] + WIDE_ONE);
      if (clr_w && (clr_i == CLR_IDX_W'(i))) begin
        d.w_cur[i] = '0;
        d.w_int[i] = 1'b0;
      end else if (pl_evt && !q.w_cfg[i][WCFG_LATCH]) begin
        d.w_cur[i] = '0;
        d.w_int[i] = 1'b0;
        d.w_pub[i] = 1'b0;
      end else if (q.w_s2[i] && !q.w_s3[i]) begin
        d.w_cur[i] = wn;
        if (wn == we) begin
          d.w_int[i] = !q.w_dir[i];
          ev[IRQ_WIDE_BIT] = 1'b1;
        end
      end
    end
    // Publish contacts at the end of a scan
    if (scan_end) begin
      d.n_pub = d.n_int;
      d.w_pub = d.w_int;
    end
    // Write address and data capture
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_full = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Register write; software write of a value wins over a count in the same cycle
    if (do_write) begin
      rw = read_word(q, wa);
      mg = merge(rw[31:0], q.w_data, q.w_strb);
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = rw[32] ? RESP_OKAY : RESP_SLVERR;
      if (wa == IRQ_MASK_OFS) begin
        d.irq_mask = mg[IRQ_W-1:0];
      end else if (in_win(wa, NARROW_CUR_BASE, NN)) begin
        d.n_cur[win_idx(wa, NARROW_CUR_BASE)] = mg[15:0];
      end else if (in_win(wa, NARROW_CFG_BASE, NN)) begin
        d.n_cfg[win_idx(wa, NARROW_CFG_BASE)] = mg;
      end else if (in_win(wa, WIDE_CUR_BASE, NW)) begin
        d.w_cur[win_idx(wa, WIDE_CUR_BASE)] = mg;
      end else if (in_win(wa, WIDE_SET_BASE, NW)) begin
        d.w_set[win_idx(wa, WIDE_SET_BASE)] = mg;
      end else if (in_win(wa, WIDE_CFG_BASE, NW)) begin
        d.w_cfg[win_idx(wa, WIDE_CFG_BASE)] = mg[WCFG_W-1:0];
      end else if (in_win(wa, DATA_BASE, ND)) begin
        d.dreg[win_idx(wa, DATA_BASE)] = mg[15:0];
      end else if (in_win(wa, WIDE_DIR_BASE, (NW + 31) / 32)) begin
        k = win_idx(wa, WIDE_DIR_BASE) * 32;
        for (int b = 0; b < 32; b++) begin
          if (k + b < NW) d.w_dir[k + b] = mg[b];
        end
      end
    end
    // Read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      rw = read_word(q, ra);
      d.rvalid = 1'b1;
      d.rdata = rw[31:0];
      d.rresp = rw[32] ? RESP_OKAY : RESP_SLVERR;
      rd_clr = (ra == IRQ_STATUS_OFS);
    end
    // Sticky status, cleared by read; a new event wins over the clear
    d.irq_st = (rd_clr ? '0 : q.irq_st) | ev;
    d.irq = |(d.irq_st & d.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Port drives
  assign narrow_contact = q.n_pub;
  assign wide_contact = q.w_pub;
  assign irq = q.irq;
  assign s_axi_awready = !q.aw_full && !q.bvalid;
  assign s_axi_wready = !q.w_full && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on counter 0 of each kind, and on all published contacts
  logic [15:0] n0_eff;
  logic [31:0] w0_eff;
  logic n0_rise;
  logic w0_rise;
  logic quiet;

  // Helper views for the checks
  assign n0_eff = narrow_eff(q.n_cfg[0], q.dreg);
  assign w0_eff = wide_eff(q.w_cfg[0], q.w_set[0], q.dreg);
  assign n0_rise = q.n_s2[0] && !q.n_s3[0];
  assign w0_rise = q.w_s2[0] && !q.w_s3[0];
  assign quiet = !do_write && !pl_evt;

  chk_narrow_step: assert property (@(posedge core_clk) disable iff (!rst_b)
    n0_rise && quiet && ($signed(q.n_cur[0]) < $signed(n0_eff))
    |=> q.n_cur[0] == 16'($past(q.n_cur[0]) + NARROW_ONE))
    else $error("narrow counter did not step by one");

  chk_narrow_halt: assert property (@(posedge core_clk) disable iff (!rst_b)
    n0_rise && quiet && (q.n_cur[0] == n0_eff) |=> $stable(q.n_cur[0]))
    else $error("narrow counter moved past its setting");

  chk_narrow_contact: assert property (@(posedge core_clk) disable iff (!rst_b)
    n0_rise && quiet && !q.n_int[0] ##1 (q.n_cur[0] == n0_eff) |-> q.n_int[0])
    else $error("narrow contact stayed off at match");

  chk_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    do_write && (wa == CLEAR_OFS) && !q.w_data[CLR_WIDE_BIT] && (q.w_data[CLR_IDX_W-1:0] == '0)
    |=> (q.n_cur[0] == '0) && !q.n_int[0])
    else $error("clear left value or contact");

  chk_pub_scan: assert property (@(posedge core_clk) disable iff (!rst_b)
    !scan_end && !pl_evt |=> $stable(q.n_pub) && $stable(q.w_pub))
    else $error("contact changed inside a scan");

  chk_eff_nonzero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (n0_eff != '0) && (n0_eff <= NARROW_SET_MASK))
    else $error("narrow setting out of range");

  chk_over_snap: assert property (@(posedge core_clk) disable iff (!rst_b)
    n0_rise && quiet && ($signed(q.n_cur[0]) > $signed(n0_eff))
    |=> (q.n_cur[0] == $past(n0_eff)) && q.n_int[0])
    else $error("oversized value not snapped to setting");

  chk_power_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
    pl_evt && !do_write && !n0_rise
    |=> q.n_cur[0] == ($past(q.n_cfg[0][NCFG_LATCH]) ? $past(q.n_cur[0]) : 16'h0000))
    else $error("power loss handling wrong");

  chk_wide_step: assert property (@(posedge core_clk) disable iff (!rst_b)
    w0_rise && quiet |=> q.w_cur[0] == ($past(q.w_dir[0]) ?
      32'($past(q.w_cur[0]) - WIDE_ONE) : 32'($past(q.w_cur[0]) + WIDE_ONE)))
    else $error("wide counter step wrong");

  chk_wide_up_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    w0_rise && quiet && !q.w_dir[0] && (32'(q.w_cur[0] + WIDE_ONE) == w0_eff) |=> q.w_int[0])
    else $error("up match did not set contact");

  chk_wide_down_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    w0_rise && quiet && q.w_dir[0] && (32'(q.w_cur[0] - WIDE_ONE) == w0_eff) |=> !q.w_int[0])
    else $error("down match did not drop contact");

  chk_wide_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
    w0_rise && quiet && (q.w_cur[0] == (q.w_dir[0] ? WIDE_NEG_MIN : WIDE_POS_MAX))
    |=> q.w_cur[0] == ($past(q.w_dir[0]) ? WIDE_POS_MAX : WIDE_NEG_MIN))
    else $error("wide wrap wrong");

endmodule

/* File: hw/plc_tally_pkg.sv */
// Shared constants of the event counter bank: register map, field layout, limits.
// Assumes a 16-bit AXI4-Lite byte address space and 32-bit data.
package plc_tally_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IDX_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 16'h0000;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 16'h0004;
  localparam logic [ADDR_W-1:0] CLEAR_OFS = 16'h0008;
  localparam logic [ADDR_W-1:0] NARROW_CUR_BASE = 16'h2000;
  localparam logic [ADDR_W-1:0] NARROW_CFG_BASE = 16'h4000;
  localparam logic [ADDR_W-1:0] WIDE_CUR_BASE = 16'h6000;
  localparam logic [ADDR_W-1:0] WIDE_SET_BASE = 16'h6200;
  localparam logic [ADDR_W-1:0] WIDE_CFG_BASE = 16'h6400;
  localparam logic [ADDR_W-1:0] WIDE_DIR_BASE = 16'h6600;
  localparam logic [ADDR_W-1:0] NARROW_PUB_BASE = 16'h6800;
  localparam logic [ADDR_W-1:0] WIDE_PUB_BASE = 16'h6900;
  localparam logic [ADDR_W-1:0] DATA_BASE = 16'h7000;
  localparam logic [ADDR_W-1:0] WORD_MASK = 16'hfffc;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int NCFG_USE_DATA = 16;
  localparam int NCFG_LATCH = 17;
  localparam int NCFG_IDX_LSB = 24;
  localparam int WCFG_USE_DATA = 0;
  localparam int WCFG_LATCH = 1;
  localparam int WCFG_IDX_LSB = 8;
  localparam int WCFG_W = 16;
  localparam int CLR_WIDE_BIT = 31;
  localparam int CLR_IDX_W = 16;
  localparam int IRQ_NARROW_BIT = 0;
  localparam int IRQ_WIDE_BIT = 1;
  localparam int IRQ_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Value limits
  localparam logic [15:0] NARROW_SET_MASK = 16'h7fff;
  localparam logic [15:0] NARROW_ONE = 16'h0001;
  localparam logic [31:0] WIDE_ONE = 32'h00000001;
  localparam logic [31:0] WIDE_POS_MAX = 32'h7fffffff;
  localparam logic [31:0] WIDE_NEG_MIN = 32'h80000000;

endpackage

/* File: testbench/tally_partner.sv */
// Far-side model: discrete count inputs, power monitor and program scan.
// Assumes its tasks are called right after a rising edge of core_clk.
`timescale 1ns/1ps
module tally_partner #(
  parameter int NN = 32,
  parameter int NW = 6
) (
  // Clock
  input wire logic core_clk,
  // Toward the counter bank
  output logic [NN-1:0] narrow_count_in,
  output logic [NW-1:0] wide_count_in,
  output logic power_loss,
  output logic scan_end
);
  // Everything idle at time zero
  initial begin
    narrow_count_in = '0;
    wide_count_in = '0;
    power_loss = 1'b0;
    scan_end = 1'b0;
  end
  // One OFF-ON-OFF switch, each level held 3 cycles so the synchroniser sees both
  task automatic pulse(input bit wide, input int i);
    if (wide) wide_count_in[i] <= 1'b1;
    else narrow_count_in[i] <= 1'b1;
    repeat (3) @(posedge core_clk);
    if (wide) wide_count_in[i] <= 1'b0;
    else narrow_count_in[i] <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // End of scan: one-cycle pulse, then let the contacts publish
  task automatic scan();
    scan_end <= 1'b1;
    @(posedge core_clk);
    scan_end <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // Supply dip seen as a rising power_loss
  task automatic power_cut();
    power_loss <= 1'b1;
    repeat (3) @(posedge core_clk);
    power_loss <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

/* File: testbench/tb_plc_event_counter_bank.sv */
// Self-checking bench of the counter bank against a small integer model.
// Assumes the reduced bank of 32 narrow, 4 wide and 2 axis counters.
`timescale 1ns/1ps
module tb_plc_event_counter_bank;
  import plc_tally_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] narrow_count_in, narrow_contact;
  logic [5:0] wide_count_in, wide_contact;
  logic power_loss, scan_end, irq, awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic [15:0] ncur [8] = '{default: '0};
  logic [15:0] nset [8] = '{default: '0};
  logic nc [8] = '{default: 1'b0};
  logic [31:0] wcur [6] = '{default: '0};
  logic [31:0] wset [6] = '{default: '0};
  logic wdir [6] = '{default: 1'b0};
  logic wc [6] = '{default: 1'b0};
  int mismatches = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and units
  always #12.5 core_clk = ~core_clk;
  tally_partner p (.core_clk(core_clk), .narrow_count_in(narrow_count_in),
    .wide_count_in(wide_count_in), .power_loss(power_loss), .scan_end(scan_end));
  plc_event_counter_bank #(.NUM_NARROW(32), .NUM_WIDE(4), .NUM_AXIS(2), .NUM_DATA(16)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .narrow_count_in(narrow_count_in),
    .wide_count_in(wide_count_in), .power_loss(power_loss), .scan_end(scan_end),
    .narrow_contact(narrow_contact), .wide_contact(wide_contact), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and model updates
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic ta, tw, done;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      done = (bvalid === 1'b1);
      r = bresp;
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!done);
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, done;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = arvalid & arready;
      done = (rvalid === 1'b1);
      v = rdata;
      rs = rresp;
      @(posedge core_clk);
      if (ta) arvalid <= 1'b0;
    end while (!done);
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic ncnt(input int i);
    logic [15:0] e;
    p.pulse(1'b0, i);
    e = ((nset[i] & 16'h7fff) == 0) ? 16'h1 : (nset[i] & 16'h7fff);
    if ($signed(ncur[i]) > $signed(e)) ncur[i] = e;
    else if (ncur[i] != e) ncur[i] = ncur[i] + 16'h1;
    if (ncur[i] == e) nc[i] = 1'b1;
  endtask
  task automatic wcnt(input int i);
    p.pulse(1'b1, i);
    wcur[i] = wdir[i] ? wcur[i] - 32'h1 : wcur[i] + 32'h1;
    if (wcur[i] == wset[i]) wc[i] = !wdir[i];
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (6000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h31c0));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    nset[0] = 16'(2 + $urandom % 4);
    wr(NARROW_CFG_BASE, {16'h0, nset[0]});
    wr(IRQ_MASK_OFS, 32'h1);
    repeat (int'(nset[0]) + 1) ncnt(0);
    rchk(NARROW_CUR_BASE, {16'h0, ncur[0]});
    chk({31'h0, narrow_contact[0]}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    p.scan();
    chk({31'h0, narrow_contact[0]}, {31'h0, nc[0]});
    rchk(IRQ_STATUS_OFS, 32'h1);
    rchk(IRQ_STATUS_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(CLEAR_OFS, 32'h0);
    ncur[0] = 16'h0;
    nc[0] = 1'b0;
    rchk(NARROW_CUR_BASE, 32'h0);
    chk({31'h0, narrow_contact[0]}, 32'h1);
    p.scan();
    chk({31'h0, narrow_contact[0]}, 32'h0);
    // Zero setting, data-register setting, snap on oversize value
    repeat (2) ncnt(1);
    rchk(NARROW_CUR_BASE + 16'h4, {16'h0, ncur[1]});
    wr(DATA_BASE + 16'h14, 32'h2);
    wr(NARROW_CFG_BASE + 16'h8, 32'h05010000);
    nset[2] = 16'h2;
    repeat (3) ncnt(2);
    rchk(NARROW_CUR_BASE + 16'h8, {16'h0, ncur[2]});
    wr(DATA_BASE + 16'h20, 32'h0000abcd);
    wstrb <= 4'h1;
    wr(DATA_BASE + 16'h20, 32'h00001234);
    wstrb <= 4'hf;
    rchk(DATA_BASE + 16'h20, 32'h0000ab34);
    nset[0] = 16'h5;
    wr(NARROW_CFG_BASE, 32'h5);
    wr(NARROW_CUR_BASE, 32'h9);
    ncur[0] = 16'h9;
    ncnt(0);
    rchk(NARROW_CUR_BASE, {16'h0, ncur[0]});
    p.scan();
    chk({31'h0, narrow_contact[0]}, {31'h0, nc[0]});
    // Latched versus general counter across a power cut
    nset[4] = 16'h9;
    nset[5] = 16'h9;
    wr(NARROW_CFG_BASE + 16'h10, 32'h00020009);
    wr(NARROW_CFG_BASE + 16'h14, 32'h9);
    ncnt(4);
    ncnt(5);
    p.power_cut();
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        ncur[i] = 16'h0;
        nc[i] = 1'b0;
      end
    end
    chk({31'h0, narrow_contact[0]}, {31'h0, nc[0]});
    rchk(NARROW_CUR_BASE + 16'h10, {16'h0, ncur[4]});
    rchk(NARROW_CUR_BASE + 16'h14, {16'h0, ncur[5]});
    ncnt(4);
    rchk(NARROW_CUR_BASE + 16'h10, {16'h0, ncur[4]});
    // Wide counter up past its setting, then down onto it
    wset[0] = 32'h2;
    wr(WIDE_SET_BASE, wset[0]);
    repeat (3) wcnt(0);
    rchk(WIDE_CUR_BASE, wcur[0]);
    p.scan();
    chk({31'h0, wide_contact[0]}, {31'h0, wc[0]});
    wr(WIDE_DIR_BASE, 32'h1);
    wdir[0] = 1'b1;
    wcnt(0);
    rchk(WIDE_CUR_BASE, wcur[0]);
    p.scan();
    chk({31'h0, wide_contact[0]}, {31'h0, wc[0]});
    // Wrap both ways on counter 0, down first
    wcur[0] = WIDE_NEG_MIN;
    wr(WIDE_CUR_BASE, wcur[0]);
    wcnt(0);
    rchk(WIDE_CUR_BASE, wcur[0]);
    wr(WIDE_DIR_BASE, 32'h0);
    wdir[0] = 1'b0;
    wcnt(0);
    rchk(WIDE_CUR_BASE, wcur[0]);
    // Axis slot with its setting from a data register pair
    wr(DATA_BASE + 16'h18, 32'h1);
    wr(DATA_BASE + 16'h1c, 32'h2);
    wr(WIDE_CFG_BASE + 16'h10, 32'h0601);
    wset[4] = 32'h00020001;
    wcur[4] = 32'h00020000;
    wr(WIDE_CUR_BASE + 16'h10, wcur[4]);
    wcnt(4);
    p.scan();
    chk({31'h0, wide_contact[4]}, {31'h0, wc[4]});
    // Wide clear, then unmapped write and read
    wr(CLEAR_OFS, 32'h80000004);
    wcur[4] = 32'h0;
    wc[4] = 1'b0;
    rchk(WIDE_CUR_BASE + 16'h10, wcur[4]);
    p.scan();
    chk({31'h0, wide_contact[4]}, {31'h0, wc[4]});
    wr(16'h1000, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(16'h1000, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    close_out();
  end
endmodule
